/* File: verilog/srx_map.svh */
// register offsets, field positions and reset values of the receiver register bank
`ifndef SRX_MAP_SVH
`define SRX_MAP_SVH

`define SRX_ADDR_W            12
`define SRX_DATA_W            16

`define SRX_OFS_STREAM_TWO    12'h001
`define SRX_OFS_ERR_ONE       12'h002
`define SRX_OFS_ERR_TWO       12'h003
`define SRX_OFS_EDH_FLAGS     12'h004

`define SRX_CTL_CONV_OFF      8
`define SRX_CTL_EXT_SEL       7
`define SRX_CTL_RSVD_HI       6
`define SRX_CTL_RSVD_LO       5
`define SRX_CTL_REMAP_OFF     4
`define SRX_CTL_CSUM_OFF      3
`define SRX_CTL_CRC_OFF       2
`define SRX_CTL_LINE_OFF      1
`define SRX_CTL_TRS_OFF       0
`define SRX_CTL_W             9
`define SRX_CTL_RESET         9'h100

`define SRX_ERR_VSTD          10
`define SRX_ERR_FF_CRC        9
`define SRX_ERR_AP_CRC        8
`define SRX_ERR_CCS           6
`define SRX_ERR_YCS           5
`define SRX_ERR_CCRC          4
`define SRX_ERR_YCRC          3
`define SRX_ERR_LNUM          2
`define SRX_ERR_SAV           1
`define SRX_ERR_EAV           0
`define SRX_ERR_RESET         16'h0000

`define SRX_EDH_FOUND         15
`define SRX_EDH_FLAGS_HI      14
`define SRX_EDH_FLAGS_LO      3
`define SRX_EDH_RESET         16'h0000

`endif

/* File: verilog/srx_pkg.sv */
// types shared by the receiver register bank
package srx_pkg;

  typedef enum logic [1:0] {
    SRX_FMT_SD,
    SRX_FMT_HD,
    SRX_FMT_3GA,
    SRX_FMT_3GB
  } srx_format_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } srx_host_req_type;

  typedef struct packed {
    logic video_standard;
    logic full_field_crc;
    logic active_picture_crc;
    logic chroma_checksum;
    logic luma_checksum;
    logic chroma_line_crc;
    logic luma_line_crc;
    logic line_count;
    logic start_active;
    logic end_active;
  } srx_first_err_type;

  typedef struct packed {
    logic chroma_checksum;
    logic luma_checksum;
    logic chroma_line_crc;
    logic luma_line_crc;
    logic line_count;
    logic start_active;
    logic end_active;
  } srx_second_err_type;

  typedef struct packed {
    logic rx_anc_unknown_flag;
    logic rx_anc_internal_already_flag;
    logic rx_anc_internal_here_flag;
    logic rx_anc_error_already_flag;
    logic rx_anc_error_here_flag;
    logic rx_field_unknown_flag;
    logic rx_field_internal_already_flag;
    logic rx_field_internal_here_flag;
    logic rx_field_error_already_flag;
    logic rx_field_error_here_flag;
    logic rx_picture_unknown_flag;
    logic rx_picture_internal_already_flag;
  } srx_edh_flags_type;

endpackage

/* File: verilog/srx_sticky_bits.sv */
// sticky event bits, set wins over a host clear
`timescale 1ns/1ps
module srx_sticky_bits #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  // events and clear
  input  wire logic [W-1:0] set_i,
  input  wire logic         clear_i,
  // held state
  output logic      [W-1:0] flags_o
);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      flags_o <= '0;
    end else begin
      flags_o <= (flags_o & ~{W{clear_i}}) | set_i;
    end
  end

endmodule

/* File: verilog/srx_reg_bank.sv */
// control, error and received check-packet registers of the video receiver
//
// How it works
// - bit 8 disables B-to-A conversion, reset 1
// - conversion only ever happens on Level B
// - bit 7 picks ancillary extraction stream, reset 0
// - bit 4 stops second-stream illegal word remap
// - bit 3 stops second-stream checksum insertion
// - bit 2 stops second-stream CRC insertion
// - bit 1 stops second-stream line number insertion
// - bit 0 stops timing word insertion; masks reset 0
// - error bit 10: video standard, HD/SD
// - bit 9 full-field CRC, bit 8 active-picture CRC
// - bits 6/5 first-stream chroma/luma checksum errors
// - bits 4/3 line CRC errors, 3G/HD only
// - bit 2 line number error, not SD
// - bits 1/0 SAV/EAV errors, all formats
// - second-stream errors in second error register
// - bit 15 packet found, bits 14-10 ancillary flags
// - bits 9-5 field flags, bits 4-3 picture flags
`timescale 1ns/1ps
`include "srx_map.svh"
module srx_reg_bank (
  // clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_i,
  // host register port
  input  wire srx_pkg::srx_host_req_type  host_req_i,
  output logic [`SRX_DATA_W-1:0]          host_rdata_o,
  output logic                            host_rvalid_o,
  // detected input format
  input  wire srx_pkg::srx_format_type    format_i,
  // error events, one-cycle pulses
  input  wire srx_pkg::srx_first_err_type  first_err_i,
  input  wire srx_pkg::srx_second_err_type second_err_i,
  // received check packet
  input  wire logic                       check_packet_found_i,
  input  wire srx_pkg::srx_edh_flags_type edh_flags_i,
  // processing controls
  output logic                            format_conversion_on_o,
  output logic                            extract_from_second_o,
  output logic                            second_stream_remap_off_o,
  output logic                            second_stream_checksum_insert_off_o,
  output logic                            second_stream_crc_insert_off_o,
  output logic                            second_stream_line_insert_off_o,
  output logic                            second_stream_timing_word_insert_off_o
);

  logic [`SRX_CTL_W-1:0]  ctrl;
  logic [`SRX_DATA_W-1:0] edh_reg;
  logic [`SRX_DATA_W-1:0] err_one;
  logic [`SRX_DATA_W-1:0] err_two;
  logic [`SRX_DATA_W-1:0] next_err_one_set;
  logic [`SRX_DATA_W-1:0] next_err_two_set;
  logic [`SRX_DATA_W-1:0] next_rdata;
  logic                   level_b;
  logic                   is_sd;
  logic                   wr_ctrl;
  logic                   clr_one;
  logic                   clr_two;

  assign level_b = (format_i == srx_pkg::SRX_FMT_3GB);
  assign is_sd   = (format_i == srx_pkg::SRX_FMT_SD);
  assign wr_ctrl = host_req_i.wr && (host_req_i.addr == `SRX_OFS_STREAM_TWO);
  assign clr_one = host_req_i.wr && (host_req_i.addr == `SRX_OFS_ERR_ONE);
  assign clr_two = host_req_i.wr && (host_req_i.addr == `SRX_OFS_ERR_TWO);

  // control register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl <= `SRX_CTL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= host_req_i.wdata[`SRX_CTL_W-1:0];
    end
  end

  // processing controls towards the datapath
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      format_conversion_on_o                 <= 1'b0;
      extract_from_second_o                  <= 1'b0;
      second_stream_remap_off_o              <= 1'b0;
      second_stream_checksum_insert_off_o    <= 1'b0;
      second_stream_crc_insert_off_o         <= 1'b0;
      second_stream_line_insert_off_o        <= 1'b0;
      second_stream_timing_word_insert_off_o <= 1'b0;
    end else begin
      format_conversion_on_o <= level_b && !ctrl[`SRX_CTL_CONV_OFF];
      extract_from_second_o  <= level_b && ctrl[`SRX_CTL_EXT_SEL];
      second_stream_remap_off_o              <= ctrl[`SRX_CTL_REMAP_OFF];
      second_stream_checksum_insert_off_o    <= ctrl[`SRX_CTL_CSUM_OFF];
      second_stream_crc_insert_off_o         <= ctrl[`SRX_CTL_CRC_OFF];
      second_stream_line_insert_off_o        <= ctrl[`SRX_CTL_LINE_OFF];
      second_stream_timing_word_insert_off_o <= ctrl[`SRX_CTL_TRS_OFF];
    end
  end

  // qualify first-stream events by format
  always_comb begin
    next_err_one_set = '0;
    next_err_one_set[`SRX_ERR_VSTD] =
      first_err_i.video_standard && (is_sd || format_i == srx_pkg::SRX_FMT_HD);
    next_err_one_set[`SRX_ERR_FF_CRC] = first_err_i.full_field_crc;
    next_err_one_set[`SRX_ERR_AP_CRC] = first_err_i.active_picture_crc;
    next_err_one_set[`SRX_ERR_CCS]    = first_err_i.chroma_checksum;
    next_err_one_set[`SRX_ERR_YCS]    = first_err_i.luma_checksum;
    next_err_one_set[`SRX_ERR_CCRC]   = first_err_i.chroma_line_crc && !is_sd;
    next_err_one_set[`SRX_ERR_YCRC]   = first_err_i.luma_line_crc && !is_sd;
    next_err_one_set[`SRX_ERR_LNUM]   = first_err_i.line_count && !is_sd;
    next_err_one_set[`SRX_ERR_SAV]    = first_err_i.start_active;
    next_err_one_set[`SRX_ERR_EAV]    = first_err_i.end_active;
  end

  // second stream exists only on Level B
  always_comb begin
    next_err_two_set = '0;
    next_err_two_set[`SRX_ERR_CCS:`SRX_ERR_EAV] = level_b ? second_err_i : 7'h00;
  end

  srx_sticky_bits #(
    .W (`SRX_DATA_W)
  ) u_err_one (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .set_i      (next_err_one_set),
    .clear_i    (clr_one),
    .flags_o    (err_one)
  );

  srx_sticky_bits #(
    .W (`SRX_DATA_W)
  ) u_err_two (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .set_i      (next_err_two_set),
    .clear_i    (clr_two),
    .flags_o    (err_two)
  );

  // received check-packet flags, captured per packet
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      edh_reg <= `SRX_EDH_RESET;
    end else if (check_packet_found_i) begin
      edh_reg[`SRX_EDH_FOUND] <= 1'b1;
      edh_reg[`SRX_EDH_FLAGS_HI:`SRX_EDH_FLAGS_LO] <= edh_flags_i;
    end
  end

  // read mux, unmapped reads return zero
  always_comb begin
    next_rdata = '0;
    unique case (host_req_i.addr)
      `SRX_OFS_STREAM_TWO: next_rdata[`SRX_CTL_W-1:0] = ctrl;
      `SRX_OFS_ERR_ONE:    next_rdata = err_one;
      `SRX_OFS_ERR_TWO:    next_rdata = err_two;
      `SRX_OFS_EDH_FLAGS:  next_rdata = edh_reg;
      default:             next_rdata = '0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      host_rdata_o  <= '0;
      host_rvalid_o <= 1'b0;
    end else begin
      host_rvalid_o <= host_req_i.rd;
      if (host_req_i.rd) begin
        host_rdata_o <= next_rdata;
      end
    end
  end

endmodule

/* File: tb/srx_reg_bank_chk.sv */
// port assertions for the receiver register bank
`timescale 1ns/1ps
`include "srx_map.svh"
module srx_reg_bank_chk (
  // clock and reset
  input wire logic                      core_clk_i,
  input wire logic                      rst_i,
  // host and event side
  input wire srx_pkg::srx_host_req_type host_req_i,
  input wire logic [15:0]               host_rdata_o,
  input wire logic                      host_rvalid_o,
  input wire srx_pkg::srx_format_type   format_i,
  input wire srx_pkg::srx_first_err_type first_err_i,
  // controls
  input wire logic                      format_conversion_on_o,
  input wire logic                      extract_from_second_o,
  input wire logic                      second_stream_remap_off_o,
  input wire logic                      second_stream_checksum_insert_off_o,
  input wire logic                      second_stream_crc_insert_off_o,
  input wire logic                      second_stream_line_insert_off_o,
  input wire logic                      second_stream_timing_word_insert_off_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire logic [4:0] masks = {second_stream_remap_off_o, second_stream_checksum_insert_off_o,
    second_stream_crc_insert_off_o, second_stream_line_insert_off_o,
    second_stream_timing_word_insert_off_o};
  wire logic ctl_wr = host_req_i.wr && host_req_i.addr == `SRX_OFS_STREAM_TWO;
  wire logic e1_wr = host_req_i.wr && host_req_i.addr == `SRX_OFS_ERR_ONE;
  wire logic e1_rd = host_req_i.rd && host_req_i.addr == `SRX_OFS_ERR_ONE;
  sequence s_ctl_quiet;
    ctl_wr ##1 !ctl_wr;
  endsequence
  sequence s_eav_read;
    first_err_i.end_active ##1 !e1_wr ##1 e1_rd;
  endsequence
  property p_mask;
    s_ctl_quiet |=> masks == $past(host_req_i.wdata[4:0], 2);
  endproperty
  property p_conv;
    format_conversion_on_o |-> $past(format_i) == srx_pkg::SRX_FMT_3GB;
  endproperty
  property p_ext;
    extract_from_second_o |-> $past(format_i) == srx_pkg::SRX_FMT_3GB;
  endproperty
  property p_rv;
    host_req_i.rd |=> host_rvalid_o;
  endproperty
  property p_eav;
    s_eav_read |=> host_rdata_o[`SRX_ERR_EAV];
  endproperty
  property p_ctl_hi;
    host_rvalid_o && $past(host_req_i.addr) == `SRX_OFS_STREAM_TWO |-> host_rdata_o[15:9] == 7'h00;
  endproperty
  property p_err1;
    host_rvalid_o && $past(host_req_i.addr) == `SRX_OFS_ERR_ONE
      |-> host_rdata_o[15:11] == 5'h00 && !host_rdata_o[7];
  endproperty
  property p_err2;
    host_rvalid_o && $past(host_req_i.addr) == `SRX_OFS_ERR_TWO |-> host_rdata_o[15:7] == 9'h000;
  endproperty
  a_mask: assert property (p_mask) else $error("mask outputs differ from write");
  a_conv: assert property (p_conv) else $error("conversion outside level B");
  a_ext: assert property (p_ext) else $error("second stream pick outside level B");
  a_rv: assert property (p_rv) else $error("read without answer");
  a_eav: assert property (p_eav) else $error("end active error not held");
  a_ctl_hi: assert property (p_ctl_hi) else $error("control upper bits not zero");
  a_err1: assert property (p_err1) else $error("first error spare bits set");
  a_err2: assert property (p_err2) else $error("second error spare bits set");
endmodule
bind srx_reg_bank srx_reg_bank_chk srx_reg_bank_chk_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .host_req_i(host_req_i), .host_rdata_o(host_rdata_o), .host_rvalid_o(host_rvalid_o),
  .format_i(format_i), .first_err_i(first_err_i),
  .format_conversion_on_o(format_conversion_on_o),
  .extract_from_second_o(extract_from_second_o),
  .second_stream_remap_off_o(second_stream_remap_off_o),
  .second_stream_checksum_insert_off_o(second_stream_checksum_insert_off_o),
  .second_stream_crc_insert_off_o(second_stream_crc_insert_off_o),
  .second_stream_line_insert_off_o(second_stream_line_insert_off_o),
  .second_stream_timing_word_insert_off_o(second_stream_timing_word_insert_off_o));

/* File: tb/srx_host_model.sv */
// host processor model on the register port
`timescale 1ns/1ps
module srx_host_model (
  // clock
  input  wire logic                 core_clk_i,
  // register port
  output srx_pkg::srx_host_req_type host_req_o,
  input  wire logic [15:0]          host_rdata_i,
  input  wire logic                 host_rvalid_i
);
  initial host_req_o = '0;
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    #1 host_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    #1 host_req_o = '0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    #1 host_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge core_clk_i);
    #1 host_req_o = '0;
    d = host_rvalid_i ? host_rdata_i : 16'hXXXX;
  endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the receiver register bank
`timescale 1ns/1ps
`include "srx_map.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  srx_pkg::srx_host_req_type host_req;
  logic [15:0] rdata, d;
  logic rvalid, conv_on, ext_sec;
  logic found = 1'b0;
  logic [4:0] masks;
  srx_pkg::srx_format_type fmt = srx_pkg::SRX_FMT_HD;
  srx_pkg::srx_first_err_type e1 = '0;
  srx_pkg::srx_second_err_type e2 = '0;
  srx_pkg::srx_edh_flags_type flags = '0;
  int err_count = 0;
  int n_compared = 0;
  always #4 core_clk_i = ~core_clk_i;
  srx_host_model srx_host_model_i (.core_clk_i(core_clk_i), .host_req_o(host_req),
    .host_rdata_i(rdata), .host_rvalid_i(rvalid));
  srx_reg_bank srx_reg_bank_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .host_req_i(host_req),
    .host_rdata_o(rdata), .host_rvalid_o(rvalid), .format_i(fmt), .first_err_i(e1),
    .second_err_i(e2), .check_packet_found_i(found), .edh_flags_i(flags),
    .format_conversion_on_o(conv_on), .extract_from_second_o(ext_sec),
    .second_stream_remap_off_o(masks[4]), .second_stream_checksum_insert_off_o(masks[3]),
    .second_stream_crc_insert_off_o(masks[2]), .second_stream_line_insert_off_o(masks[1]),
    .second_stream_timing_word_insert_off_o(masks[0]));
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic rd(input logic [11:0] a);
    srx_host_model_i.rd(a, d);
  endtask
  task automatic t_reset;
    rd(`SRX_OFS_STREAM_TWO);
    `CHK(d, 16'h0100)
    for (int a = 2; a < 6; a++) begin
      rd(12'(a));
      `CHK(d, 16'h0000)
    end
    `CHK({conv_on, ext_sec, masks}, 7'h00)
  endtask
  task automatic t_ctrl;
    fmt = srx_pkg::SRX_FMT_3GB;
    srx_host_model_i.wr(`SRX_OFS_STREAM_TWO, 16'hFFFF);
    rd(`SRX_OFS_STREAM_TWO);
    `CHK(d, 16'h01FF)
    `CHK({conv_on, ext_sec, masks}, 7'h3F)
    for (int i = 0; i < 5; i++) begin
      srx_host_model_i.wr(`SRX_OFS_STREAM_TWO, 16'h0001 << i);
      cyc(1);
      `CHK(masks, 5'h01 << i)
      `CHK({conv_on, ext_sec}, 2'b10)
    end
    srx_host_model_i.wr(`SRX_OFS_STREAM_TWO, 16'h0080);
    for (int f = 0; f < 4; f++) begin
      fmt = srx_pkg::srx_format_type'(f);
      cyc(2);
      `CHK({conv_on, ext_sec}, (f == 3) ? 2'b11 : 2'b00)
    end
  endtask
  task automatic t_err;
    logic [15:0] exp1 [4] = '{16'h0763, 16'h077F, 16'h037F, 16'h037F};
    for (int f = 0; f < 4; f++) begin
      fmt = srx_pkg::srx_format_type'(f);
      e1 = '1;
      e2 = '1;
      cyc(1);
      e1 = '0;
      e2 = '0;
      rd(`SRX_OFS_ERR_ONE);
      `CHK(d, exp1[f])
      rd(`SRX_OFS_ERR_TWO);
      `CHK(d, (f == 3) ? 16'h007F : 16'h0000)
      rd(`SRX_OFS_ERR_ONE);
      `CHK(d, exp1[f])
      srx_host_model_i.wr(`SRX_OFS_ERR_ONE, 16'hFFFF);
      srx_host_model_i.wr(`SRX_OFS_ERR_TWO, 16'hFFFF);
      rd(`SRX_OFS_ERR_ONE);
      `CHK(d, 16'h0000)
    end
  endtask
  task automatic t_edh;
    flags = 12'hA5A;
    found = 1'b1;
    cyc(1);
    found = 1'b0;
    repeat (2) begin
      rd(`SRX_OFS_EDH_FLAGS);
      `CHK(d, 16'hD2D0)
      srx_host_model_i.wr(`SRX_OFS_EDH_FLAGS, 16'h0000);
    end
  endtask
  task automatic finish_test;
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    cyc(4);
    rst_i = 1'b0;
    t_reset;
    t_ctrl;
    t_err;
    t_edh;
    finish_test;
  end
  initial begin
    #100000;
    err_count++;
    finish_test;
  end
endmodule
